// ==== src/input_qualifier_regs.svh ====
// Purpose: Offsets, reset values and timing figures of the input qualifier
// Assumes: Byte addresses, channel block of 32 bytes, register at low 5 bits
// Notes:   Times are in their own units; cycle counts are derived in the module
`ifndef INPUT_QUALIFIER_REGS_SVH
`define INPUT_QUALIFIER_REGS_SVH

`define NUM_CH          8
`define OFS_CFG         5'h00
`define OFS_ACT         5'h04
`define OFS_REL         5'h08
`define OFS_PICKUP      5'h0C
`define OFS_DROPOFF     5'h10
`define OFS_COUNT       5'h14
`define OFS_CLEAR       5'h18
`define OFS_VOLT        5'h1C

`define CFG_POL_BIT     0
`define CFG_AC_BIT      1
`define CFG_STATE_BIT   4
`define CFG_ENERG_BIT   5
`define CLEAR_BIT       0

`define RST_POL         1'b0
`define RST_AC          1'b0
`define RST_ACT         11'h0370
`define RST_REL         11'h0258
`define RST_DELAY       21'h00_0000

`define LEVEL_MV        19'h0064
`define AC_REL_MV       19'h000A
`define DLY_MAX         21'h1F_FFFF

`define CLK_HZ          20000000
`define DLY_STEP_US     1000
`define SCAN_TIME_MS    5
`define AC_EXTRA_MS     30

`endif

// ==== src/input_qualifier_pkg.sv ====
// Purpose: Types shared by the input qualifier
// Assumes: Constants come from the register header
// Notes:   Whole module state is one packed struct
`include "input_qualifier_regs.svh"

package input_qualifier_pkg;

   typedef struct packed {
      logic [7:0]  addr;
      logic [31:0] wdata;
      logic        wr;
      logic        rd;
   } reg_req_s;

   typedef struct packed {
      logic        nc_pol;
      logic        ac_en;
      logic [10:0] act;
      logic [10:0] rel;
      logic [20:0] pickup;
      logic [20:0] dropoff;
      logic        energized;
      logic        state;
      logic [20:0] dly;
      logic [31:0] cnt;
      logic [18:0] volt;
   } chan_s;

   typedef chan_s [`NUM_CH-1:0] chan_arr_t;

   typedef struct packed {
      logic [23:0] ms_div;
      logic [2:0]  scan_ms;
      logic [31:0] rdata;
      chan_arr_t   ch;
   } state_s;

endpackage

// ==== src/digital_input_qualifier.sv ====
// Purpose: Eight-channel voltage qualifier with hysteresis, delays and counters
// Assumes: Voltages in mV from on-chip measurement logic on clk_in
// Notes:   Delays resolve to the 5 ms scan; state changes only at a scan
`timescale 1ns/1ns
`include "input_qualifier_regs.svh"

module digital_input_qualifier
   import input_qualifier_pkg::*;
#(
   parameter int MS_CYCLES = (`CLK_HZ / 1000000) * `DLY_STEP_US
) (
   input  wire logic                 clk_in,
   input  wire logic                 rst_n_in,
   input  wire logic                 ce_in,
   input  wire logic [`NUM_CH-1:0][18:0] volt_mv_in,
   input  wire reg_req_s             req_in,
   output logic      [31:0]          rdata_out,
   output logic      [`NUM_CH-1:0]   input_channel_out
);

   localparam logic [23:0] MS_LAST   = 24'(MS_CYCLES - 1);
   localparam logic [2:0]  SCAN_LAST = 3'(`SCAN_TIME_MS - 1);
   localparam logic [21:0] AC_EXTRA  = 22'(`AC_EXTRA_MS);

   localparam chan_s CH_RST = '{nc_pol:  `RST_POL,
                                ac_en:   `RST_AC,
                                act:     `RST_ACT,
                                rel:     `RST_REL,
                                pickup:  `RST_DELAY,
                                dropoff: `RST_DELAY,
                                default: '0};
   localparam state_s S_RST = '{ch: '{default: CH_RST}, default: '0};

   state_s s_q;
   state_s s_d;
   logic   ms_tick;
   logic   scan_hit;

   function automatic logic reg_hit(input logic [7:0] addr,
                                    input int         ch,
                                    input logic [4:0] ofs);
      reg_hit = (addr[7:5] == 3'(ch)) && (addr[4:0] == ofs);
   endfunction

   function automatic logic [18:0] level_mv(input logic [10:0] lvl);
      level_mv = 19'(lvl) * `LEVEL_MV;
   endfunction

   function automatic logic [18:0] release_mv(input chan_s c);
      // Tenth of activation: 0.1 V steps times 10 mV
      release_mv = c.ac_en ? 19'(c.act) * `AC_REL_MV : level_mv(c.rel);
   endfunction

   function automatic logic [21:0] drop_need(input chan_s c);
      drop_need = 22'(c.dropoff) + (c.ac_en ? AC_EXTRA : 22'h00_0000);
   endfunction

   always_comb begin
      logic        clr;
      logic        e;
      logic        tgt;
      logic [21:0] need;
      chan_s       rc;
      clr      = 1'b0;
      e        = 1'b0;
      tgt      = 1'b0;
      need     = '0;
      rc       = '0;
      s_d      = s_q;
      ms_tick  = 1'b0;
      scan_hit = 1'b0;
      if (ce_in) begin
         s_d.rdata = '0;
         if (s_q.ms_div == MS_LAST) begin
            s_d.ms_div = '0;
            ms_tick    = 1'b1;
         end else begin
            s_d.ms_div = s_q.ms_div + 24'h00_0001;
         end
         if (ms_tick) begin
            if (s_q.scan_ms == SCAN_LAST) begin
               s_d.scan_ms = '0;
               scan_hit    = 1'b1;
            end else begin
               s_d.scan_ms = s_q.scan_ms + 3'h1;
            end
         end
         for (int i = 0; i < `NUM_CH; i++) begin
            s_d.ch[i].volt = volt_mv_in[i];
            if (req_in.wr) begin
               if (reg_hit(req_in.addr, i, `OFS_CFG)) begin
                  s_d.ch[i].nc_pol = req_in.wdata[`CFG_POL_BIT];
                  s_d.ch[i].ac_en  = req_in.wdata[`CFG_AC_BIT];
               end
               if (reg_hit(req_in.addr, i, `OFS_ACT)) begin
                  s_d.ch[i].act = req_in.wdata[10:0];
               end
               if (reg_hit(req_in.addr, i, `OFS_REL)) begin
                  s_d.ch[i].rel = req_in.wdata[10:0];
               end
               if (reg_hit(req_in.addr, i, `OFS_PICKUP)) begin
                  s_d.ch[i].pickup = req_in.wdata[20:0];
               end
               if (reg_hit(req_in.addr, i, `OFS_DROPOFF)) begin
                  s_d.ch[i].dropoff = req_in.wdata[20:0];
               end
            end
            clr = req_in.wr && reg_hit(req_in.addr, i, `OFS_CLEAR) &&
                  req_in.wdata[`CLEAR_BIT];
            if (clr) begin
               s_d.ch[i].cnt = '0;
            end
            // Delay runs in ms while target and state differ
            tgt = s_q.ch[i].energized ^ s_q.ch[i].nc_pol;
            if (ms_tick && (tgt != s_q.ch[i].state) && (s_q.ch[i].dly != `DLY_MAX)) begin
               s_d.ch[i].dly = s_q.ch[i].dly + 21'h00_0001;
            end
            if (scan_hit) begin
               e = s_q.ch[i].energized;
               if (s_q.ch[i].volt > level_mv(s_q.ch[i].act)) begin
                  e = 1'b1;
               end else if (s_q.ch[i].volt < release_mv(s_q.ch[i])) begin
                  e = 1'b0;
               end
               s_d.ch[i].energized = e;
               tgt = e ^ s_q.ch[i].nc_pol;
               need = tgt ? 22'(s_q.ch[i].pickup) : drop_need(s_q.ch[i]);
               if (tgt == s_q.ch[i].state) begin
                  s_d.ch[i].dly = '0;
               end else if ({1'b0, s_q.ch[i].dly} >= need) begin
                  s_d.ch[i].state = tgt;
                  s_d.ch[i].dly   = '0;
                  // Count rise, wraps; counts even over a clear
                  if (tgt) begin
                     s_d.ch[i].cnt = (clr ? 32'h0000_0000 : s_q.ch[i].cnt) + 32'h0000_0001;
                  end
               end
            end
         end
         if (req_in.rd && (req_in.addr[1:0] == 2'h0)) begin
            rc = s_q.ch[req_in.addr[7:5]];
            unique case (req_in.addr[4:0])
               `OFS_CFG: begin
                  s_d.rdata[`CFG_POL_BIT]   = rc.nc_pol;
                  s_d.rdata[`CFG_AC_BIT]    = rc.ac_en;
                  s_d.rdata[`CFG_STATE_BIT] = rc.state;
                  s_d.rdata[`CFG_ENERG_BIT] = rc.energized;
               end
               `OFS_ACT:     s_d.rdata = 32'(rc.act);
               // Reads the stored setting even while AC mode overrides it
               `OFS_REL:     s_d.rdata = 32'(rc.rel);
               `OFS_PICKUP:  s_d.rdata = 32'(rc.pickup);
               `OFS_DROPOFF: s_d.rdata = 32'(rc.dropoff);
               `OFS_COUNT:   s_d.rdata = rc.cnt;
               `OFS_VOLT:    s_d.rdata = 32'(rc.volt);
               default:      s_d.rdata = '0;
            endcase
         end
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         s_q <= S_RST;
      end else begin
         s_q <= s_d;
      end
   end

   assign rdata_out = s_q.rdata;

   always_comb begin
      for (int i = 0; i < `NUM_CH; i++) begin
         input_channel_out[i] = s_q.ch[i].state;
      end
   end

   // Checks watch channel 0, except a_separate (channel 1), a_ce_freeze (all state), a_rdata_idle (no read), a_odd_read (any read); channels share one loop
   logic clr0;
   logic wr_act0;
   logic rd_volt0;
   assign clr0     = ce_in && req_in.wr && reg_hit(req_in.addr, 0, `OFS_CLEAR) &&
                     req_in.wdata[`CLEAR_BIT];
   assign wr_act0  = ce_in && req_in.wr && reg_hit(req_in.addr, 0, `OFS_ACT);
   assign rd_volt0 = ce_in && req_in.rd && reg_hit(req_in.addr, 0, `OFS_VOLT);

   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!rst_n_in);

   property p_scan_only;
      !$stable(s_q.ch[0].state) |-> $past(scan_hit);
   endproperty
   a_scan_only: assert property (p_scan_only) else $error("state moved off scan");

   property p_pickup;
      $rose(s_q.ch[0].state) |-> $past(s_q.ch[0].dly) >= $past(s_q.ch[0].pickup);
   endproperty
   a_pickup: assert property (p_pickup) else $error("rise before pickup delay");

   property p_dropoff;
      $fell(s_q.ch[0].state) |-> $past({1'b0, s_q.ch[0].dly}) >= $past(drop_need(s_q.ch[0]));
   endproperty
   a_dropoff: assert property (p_dropoff) else $error("fall before drop delay");

   property p_ac_extra;
      $fell(s_q.ch[0].state) && $past(s_q.ch[0].ac_en) |-> $past(s_q.ch[0].dly) >= 21'h00_001E;
   endproperty
   a_ac_extra: assert property (p_ac_extra) else $error("AC drop under 30 ms");

   property p_count;
      $rose(s_q.ch[0].state) && !$past(clr0) |-> s_q.ch[0].cnt == $past(s_q.ch[0].cnt) + 32'h1;
   endproperty
   a_count: assert property (p_count) else $error("counter missed a rise");

   property p_wrap;
      $rose(s_q.ch[0].state) && !$past(clr0) && $past(s_q.ch[0].cnt) == 32'hFFFF_FFFF
         |-> s_q.ch[0].cnt == 32'h0000_0000;
   endproperty
   a_wrap: assert property (p_wrap) else $error("counter did not wrap");

   property p_clear;
      clr0 ##1 $stable(s_q.ch[0].state) |-> s_q.ch[0].cnt == 32'h0000_0000;
   endproperty
   a_clear: assert property (p_clear) else $error("clear left counter");

   property p_no_above;
      scan_hit && !req_in.wr && !s_q.ch[0].nc_pol && s_q.ch[0].volt > level_mv(s_q.ch[0].act)
         |=> s_q.ch[0].energized ##0 (s_q.ch[0].energized ^ s_q.ch[0].nc_pol);
   endproperty
   a_no_above: assert property (p_no_above) else $error("NO input not active");

   property p_nc_above;
      scan_hit && !req_in.wr && s_q.ch[0].nc_pol && s_q.ch[0].volt > level_mv(s_q.ch[0].act)
         |=> !(s_q.ch[0].energized ^ s_q.ch[0].nc_pol);
   endproperty
   a_nc_above: assert property (p_nc_above) else $error("NC input not inactive");

   property p_nc_below;
      scan_hit && !req_in.wr && s_q.ch[0].nc_pol && s_q.ch[0].volt <= level_mv(s_q.ch[0].act) &&
         s_q.ch[0].volt < release_mv(s_q.ch[0]) |=> (s_q.ch[0].energized ^ s_q.ch[0].nc_pol);
   endproperty
   a_nc_below: assert property (p_nc_below) else $error("NC input not active");

   property p_below;
      scan_hit && s_q.ch[0].volt <= level_mv(s_q.ch[0].act) &&
         s_q.ch[0].volt < release_mv(s_q.ch[0]) |=> !s_q.ch[0].energized;
   endproperty
   a_below: assert property (p_below) else $error("below release kept energized");

   property p_ac_release;
      scan_hit && s_q.ch[0].ac_en && s_q.ch[0].volt < 19'(s_q.ch[0].act) * 19'h000A
         |=> !s_q.ch[0].energized;
   endproperty
   a_ac_release: assert property (p_ac_release) else $error("AC release not tenth");

   property p_hold;
      scan_hit && s_q.ch[0].volt <= level_mv(s_q.ch[0].act) &&
         s_q.ch[0].volt >= release_mv(s_q.ch[0]) |=> $stable(s_q.ch[0].energized);
   endproperty
   a_hold: assert property (p_hold) else $error("hysteresis band changed state");

   property p_volt_read;
      rd_volt0 |=> rdata_out == 32'($past(s_q.ch[0].volt));
   endproperty
   a_volt_read: assert property (p_volt_read) else $error("voltage read wrong");

   property p_separate;
      wr_act0 |=> $stable(s_q.ch[1].act);
   endproperty
   a_separate: assert property (p_separate) else $error("threshold shared");

   property p_cfg_write;
      ce_in && req_in.wr && reg_hit(req_in.addr, 0, `OFS_CFG)
         |=> s_q.ch[0].nc_pol == $past(req_in.wdata[`CFG_POL_BIT]);
   endproperty
   a_cfg_write: assert property (p_cfg_write) else $error("polarity write lost");

   // Clock enable low must hold every bit, dividers and delays included
   property p_ce_freeze;
      !ce_in |=> $stable(s_q);
   endproperty
   a_ce_freeze: assert property (p_ce_freeze) else $error("state moved while disabled");

   property p_rdata_idle;
      ce_in && !req_in.rd |=> rdata_out == 32'h0000_0000;
   endproperty
   a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read");

   property p_odd_read;
      ce_in && req_in.rd && (req_in.addr[1:0] != 2'h0) |=> rdata_out == 32'h0000_0000;
   endproperty
   a_odd_read: assert property (p_odd_read) else $error("unaligned read not zero");

   c_rise:    cover property ($rose(s_q.ch[0].state));
   c_fall:    cover property ($fell(s_q.ch[0].state) && s_q.ch[0].ac_en);
   c_clear:   cover property (clr0 ##1 s_q.ch[0].cnt == 32'h0000_0000);
   c_nc_rise: cover property ($rose(s_q.ch[0].state) && s_q.ch[0].nc_pol);
   c_ce_hold: cover property (!ce_in ##1 ce_in);

endmodule

// ==== tb/volt_source_model.sv ====
// Purpose: Per-channel voltage measurement standing in front of the qualifier
// Assumes: Levels in mV, set by the bench through set_level
// Notes:   Output is registered, so a new level shows one edge after the call
`timescale 1ns/1ns
`include "input_qualifier_regs.svh"
module volt_source_model (
   input  wire logic                     clk_in,
   output logic      [`NUM_CH-1:0][18:0] volt_mv_out
);
   logic [`NUM_CH-1:0][18:0] level_q;

   // Output stays unknown until the first edge; the qualifier is in reset then
   initial begin
      level_q = '0;
   end

   // Called at an edge or just after it; a call at the edge itself, as after wr, can race the register
   task automatic set_level(input int ch, input logic [18:0] mv);
      level_q[ch] = mv;
   endtask

   always_ff @(posedge clk_in) begin
      volt_mv_out <= level_q;
   end
endmodule

// ==== tb/testbench.sv ====
// Purpose: Register and qualification checks of the input qualifier
// Assumes: MS_CYCLES of 4, so one scan is 20 clocks
// Notes:   Counter wrap is not reached; clock enable is dropped once near the end
`timescale 1ns/1ns
`include "input_qualifier_regs.svh"
module testbench;
   import input_qualifier_pkg::*;
   localparam int MS = 4;
   logic                     clk_in;
   logic                     rst_n_in;
   logic                     ce_in;
   reg_req_s                 req;
   logic [`NUM_CH-1:0][18:0] volt;
   logic [31:0]              rdata;
   logic [`NUM_CH-1:0]       chan;
   int                       bad_count;
   int                       checks_done;
   int                       el;

   volt_source_model u_src (.clk_in(clk_in), .volt_mv_out(volt));

   digital_input_qualifier #(.MS_CYCLES(MS)) DUT (
      .clk_in            (clk_in),
      .rst_n_in          (rst_n_in),
      .ce_in             (ce_in),
      .volt_mv_in        (volt),
      .req_in            (req),
      .rdata_out         (rdata),
      .input_channel_out (chan)
   );

   initial begin
      clk_in = 1'b0;
      forever #25 clk_in = ~clk_in;
   end

   task automatic tally_and_finish();
      if (bad_count == 0 && checks_done > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic wr(input int ch, input logic [4:0] ofs, input logic [31:0] d);
      @(posedge clk_in);
      req <= '{addr: {ch[2:0], ofs}, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk_in);
      req.wr <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe
   task automatic rchk(input string name, input int ch, input logic [4:0] ofs,
                       input logic [31:0] exp);
      @(posedge clk_in);
      req <= '{addr: {ch[2:0], ofs}, wdata: '0, wr: 1'b0, rd: 1'b1};
      @(posedge clk_in);
      req.rd <= 1'b0;
      #1;
      chk(name, exp, rdata);
   endtask

   // Bounded wait; a miss ends the run
   task automatic wait_chan(input int ch, input logic val, input int lim, output int n);
      n = 0;
      while (chan[ch] !== val && n < lim) begin
         @(posedge clk_in);
         #1;
         n++;
      end
      chk("channel state", {31'h0000_0000, val}, {31'h0000_0000, chan[ch]});
      if (chan[ch] !== val) begin
         tally_and_finish();
      end
   endtask

   task automatic hold_chan(input int ch, input logic val, input int cyc);
      logic ok;
      ok = 1'b1;
      repeat (cyc) begin
         @(posedge clk_in);
         #1;
         ok &= (chan[ch] === val);
      end
      chk("channel held", 32'h0000_0001, {31'h0000_0000, ok});
   endtask

   initial begin
      rst_n_in = 1'b0;
      ce_in = 1'b1;
      req = '0;
      bad_count = 0;
      checks_done = 0;
      repeat (20) @(posedge clk_in);
      rst_n_in <= 1'b1;
      // Reset values, an unaligned read and a voltage read
      rchk("cfg", 0, `OFS_CFG, 32'h0000_0000);
      rchk("activate", 0, `OFS_ACT, 32'h0000_0370);
      rchk("release", 0, `OFS_REL, 32'h0000_0258);
      rchk("pickup", 0, `OFS_PICKUP, 32'h0000_0000);
      rchk("dropoff", 0, `OFS_DROPOFF, 32'h0000_0000);
      rchk("count", 0, `OFS_COUNT, 32'h0000_0000);
      rchk("odd address", 0, 5'h05, 32'h0000_0000);
      u_src.set_level(3, 19'h0_3039);
      repeat (3) @(posedge clk_in);
      rchk("voltage", 3, `OFS_VOLT, 32'h0000_3039);
      // Normally open with hysteresis and counting
      u_src.set_level(0, 19'h1_5F90);
      wait_chan(0, 1'b1, 45, el);
      rchk("count", 0, `OFS_COUNT, 32'h0000_0001);
      u_src.set_level(0, 19'h1_1170);
      hold_chan(0, 1'b1, 60);
      u_src.set_level(0, 19'h0_C350);
      wait_chan(0, 1'b0, 45, el);
      u_src.set_level(0, 19'h1_5F90);
      wait_chan(0, 1'b1, 45, el);
      rchk("count", 0, `OFS_COUNT, 32'h0000_0002);
      wr(0, `OFS_CLEAR, 32'h0000_0001);
      wr(0, `OFS_COUNT, 32'h0000_0007);
      rchk("count", 0, `OFS_COUNT, 32'h0000_0000);
      // Normally closed
      wr(1, `OFS_CFG, 32'h0000_0001);
      wait_chan(1, 1'b1, 45, el);
      u_src.set_level(1, 19'h1_5F90);
      wait_chan(1, 1'b0, 45, el);
      rchk("cfg", 1, `OFS_CFG, 32'h0000_0021);
      // Thresholds kept per channel
      wr(2, `OFS_ACT, 32'h0000_01F4);
      u_src.set_level(2, 19'h0_EA60);
      u_src.set_level(4, 19'h0_EA60);
      wait_chan(2, 1'b1, 45, el);
      hold_chan(4, 1'b0, 40);
      rchk("activate", 4, `OFS_ACT, 32'h0000_0370);
      // Delays of 20 ms, at least 80 clocks
      wr(5, `OFS_PICKUP, 32'h0000_0014);
      wr(5, `OFS_DROPOFF, 32'h0000_0014);
      u_src.set_level(5, 19'h1_5F90);
      wait_chan(5, 1'b1, 200, el);
      chk("pickup time", 32'h0000_0001, 32'(el >= 20 * MS));
      u_src.set_level(5, 19'h0_0000);
      wait_chan(5, 1'b0, 200, el);
      chk("dropoff time", 32'h0000_0001, 32'(el >= 20 * MS));
      // AC mode: release at a tenth of activation, 30 ms extra drop delay
      wr(6, `OFS_CFG, 32'h0000_0002);
      u_src.set_level(6, 19'h1_5F90);
      wait_chan(6, 1'b1, 45, el);
      u_src.set_level(6, 19'h0_4E20);
      hold_chan(6, 1'b1, 200);
      u_src.set_level(6, 19'h0_0000);
      wait_chan(6, 1'b0, 250, el);
      chk("ac drop time", 32'h0000_0001, 32'(el >= 30 * MS));
      rchk("release", 6, `OFS_REL, 32'h0000_0258);
      // Channel 0 again, so the checks on it see polarity and AC mode
      wr(0, `OFS_CFG, 32'h0000_0001);
      wait_chan(0, 1'b0, 45, el);
      u_src.set_level(0, 19'h0_0000);
      wait_chan(0, 1'b1, 45, el);
      wr(0, `OFS_PICKUP, 32'h0000_000A);
      wr(0, `OFS_CFG, 32'h0000_0002);
      wait_chan(0, 1'b0, 250, el);
      chk("ac drop time", 32'h0000_0001, 32'(el >= 29 * MS));
      u_src.set_level(0, 19'h1_5F90);
      wait_chan(0, 1'b1, 200, el);
      chk("pickup time", 32'h0000_0001, 32'(el >= 10 * MS));
      rchk("count", 0, `OFS_COUNT, 32'h0000_0002);
      // Clock enable low freezes the scan
      @(posedge clk_in);
      ce_in <= 1'b0;
      u_src.set_level(7, 19'h1_5F90);
      hold_chan(7, 1'b0, 60);
      @(posedge clk_in);
      ce_in <= 1'b1;
      wait_chan(7, 1'b1, 45, el);
      tally_and_finish();
   end
endmodule
